// ==== common/bfo_pkg.sv ====
// Package for the bit and flag operations unit: register map, fields,
// operation codes and the command carrier.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
//
// Notes on behaviour
// (RULE1) Shift right: result bit n takes operand bit n+1 for n from 0 to 6.
// (RULE2) Shift right keeps the sign bit; the bit shifted out goes to carry.
// (RULE3) Nibble swap exchanges the low and high halves in one operation.
// (RULE4) Status bit set forces the chosen flag to one; clear forces it to zero.
// (RULE5) Bit store copies an operand bit to transfer flag; load does reverse.
// (RULE6) Dedicated ops set or clear carry, negative, zero; no other flag moves.
// (RULE7) Dedicated ops set or clear the global interrupt enable flag.
// (RULE8) Dedicated ops set or clear sign, overflow, transfer and half-carry flags.
// (RULE9) Shift updates Z,C,N,V; swap and load touch none; store only transfer.
package bfo_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADR_CMD = 4'h0;
  localparam logic [3:0] ADR_OPERAND = 4'h4;
  localparam logic [3:0] ADR_RESULT = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hc;

  localparam logic [7:0] OPERAND_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Position of the illegal-command flag in the result register
  localparam int RES_ILLEGAL_BIT = 8;

  // ****************************************************************
  // Status register flag positions
  // ****************************************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ****************************************************************
  // Operation codes; dedicated flag ops are 1_fff_v (flag, value)
  // ****************************************************************
  typedef enum logic [4:0] {
    arith_shift_right = 5'h00,
    nibble_swap = 5'h01,
    status_bit_set = 5'h02,
    status_bit_clear = 5'h03,
    reg_bit_to_transfer_flag = 5'h04,
    transfer_flag_to_reg_bit = 5'h05,
    carry_clear_op = 5'h10,
    carry_set_op = 5'h11,
    zero_clear_op = 5'h12,
    zero_set_op = 5'h13,
    negative_clear_op = 5'h14,
    negative_set_op = 5'h15,
    overflow_clear_op = 5'h16,
    overflow_set_op = 5'h17,
    sign_clear_op = 5'h18,
    sign_set_op = 5'h19,
    half_carry_clear_op = 5'h1a,
    half_carry_set_op = 5'h1b,
    transfer_flag_clear_op = 5'h1c,
    transfer_flag_set_op = 5'h1d,
    global_irq_disable_op = 5'h1e,
    global_irq_enable_op = 5'h1f
  } bfo_op_t;

  // Command word, low byte of a write to ADR_CMD
  typedef struct packed {
    logic [2:0] bitsel;
    bfo_op_t op;
  } bfo_cmd_t;

endpackage : bfo_pkg

// ==== logic/bfo_unit.sv ====
// Bit and flag operations unit: shift, swap, status bit and transfer ops.
// Assumes a classic Wishbone master on clk_i; one access at a time.
`timescale 1ns/10ps
module bfo_unit
  import bfo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [7:0] status_register_o,
  output logic [7:0] result_o
);

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  logic [7:0] operand;
  logic [7:0] result;
  logic [7:0] status_register;
  logic illegal;
  logic wr;
  logic exec;
  bfo_cmd_t cmd_in;

  // Writes land on the edge where ack is seen high, matching the master
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign exec = wr && (adr_i == ADR_CMD);
  assign cmd_in = bfo_cmd_t'(dat_i[7:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_o) begin
      unique case (adr_i)
        ADR_OPERAND: dat_o <= {24'h00_0000, operand};
        ADR_RESULT: dat_o <= {23'h00_0000, illegal, result};
        ADR_STATUS: dat_o <= {24'h00_0000, status_register};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand <= OPERAND_RST;
    end else if (wr && adr_i == ADR_OPERAND) begin
      operand <= dat_i[7:0];
    end
  end

  // ****************************************************************
  // Execution
  // ****************************************************************
  logic [7:0] next_result;
  logic [7:0] next_status;
  logic next_writes_rd;
  logic next_illegal;

  always_comb begin
    next_result = result;
    next_status = status_register;
    next_writes_rd = 1'b0;
    next_illegal = 1'b0;
    case (cmd_in.op)
      arith_shift_right: begin
        next_result = {operand[7], operand[7:1]}; // [RULE1] [RULE2]
        next_writes_rd = 1'b1;
        next_status[FLAG_C] = operand[0]; // [RULE2]
        next_status[FLAG_N] = operand[7]; // [RULE9]
        next_status[FLAG_Z] = (operand[7:1] == 7'h00) && !operand[7]; // [RULE9]
        next_status[FLAG_V] = operand[7] ^ operand[0]; // [RULE9]
      end
      nibble_swap: begin
        next_result = {operand[3:0], operand[7:4]}; // [RULE3]
        next_writes_rd = 1'b1;
      end
      status_bit_set: next_status[cmd_in.bitsel] = 1'b1; // [RULE4]
      status_bit_clear: next_status[cmd_in.bitsel] = 1'b0; // [RULE4]
      reg_bit_to_transfer_flag: begin
        next_status[FLAG_T] = operand[cmd_in.bitsel]; // [RULE5] [RULE9]
      end
      transfer_flag_to_reg_bit: begin
        next_result = operand;
        next_result[cmd_in.bitsel] = status_register[FLAG_T]; // [RULE5]
        next_writes_rd = 1'b1;
      end
      default: begin
        // Dedicated flag ops carry the flag index and its new value
        if (cmd_in.op[4]) begin
          next_status[cmd_in.op[3:1]] = cmd_in.op[0]; // [RULE6] [RULE7] [RULE8]
        end else begin
          next_illegal = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_register <= STATUS_RST;
    end else if (exec) begin
      status_register <= next_status;
    end else if (wr && adr_i == ADR_STATUS) begin
      status_register <= dat_i[7:0];
    end
  end

  // Result keeps its value for ops that do not write a destination
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= RESULT_RST;
    end else if (exec && next_writes_rd) begin
      result <= next_result;
    end
  end

  // Unknown codes change nothing but are flagged for software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal <= 1'b0;
    end else if (exec) begin
      illegal <= next_illegal;
    end
  end

  assign status_register_o = status_register;
  assign result_o = result;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_exec_of(logic [4:0] o);
    exec && cmd_in.op == o;
  endsequence

  sequence s_ded_flag(logic [2:0] f);
    exec && cmd_in.op[4] && cmd_in.op[3:1] == f;
  endsequence

  a_ack_single_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_shift_low_bits: assert property ( // [RULE1]
    s_exec_of(arith_shift_right) |=> result[6:0] == $past(operand[7:1]))
    else $error("shift result bits wrong");

  a_shift_sign_carry: assert property ( // [RULE2]
    s_exec_of(arith_shift_right) |=>
      result[7] == $past(operand[7]) && status_register[FLAG_C] == $past(operand[0]))
    else $error("shift sign or carry wrong");

  a_swap_nibbles: assert property ( // [RULE3]
    s_exec_of(nibble_swap) |=>
      result == {$past(operand[3:0]), $past(operand[7:4])} ##1 result == $past(result))
    else $error("nibble swap wrong");

  a_status_bit_ops: assert property ( // [RULE4]
    (s_exec_of(status_bit_set) |=> status_register[$past(cmd_in.bitsel)]) and
    (s_exec_of(status_bit_clear) |=> !status_register[$past(cmd_in.bitsel)]))
    else $error("status bit set or clear wrong");

  a_transfer_moves: assert property ( // [RULE5]
    (s_exec_of(reg_bit_to_transfer_flag) |=>
      status_register[FLAG_T] == $past(operand[cmd_in.bitsel])) and
    (s_exec_of(transfer_flag_to_reg_bit) |=>
      result[$past(cmd_in.bitsel)] == $past(status_register[FLAG_T])))
    else $error("transfer flag copy wrong");

  a_czn_dedicated: assert property ( // [RULE6]
    (s_ded_flag(FLAG_C) or s_ded_flag(FLAG_Z) or s_ded_flag(FLAG_N)) |=>
      status_register == (($past(status_register) & ~(8'h01 << $past(cmd_in.op[3:1])))
        | ({7'h00, $past(cmd_in.op[0])} << $past(cmd_in.op[3:1]))))
    else $error("dedicated C/Z/N op wrong");

  a_irq_dedicated: assert property ( // [RULE7]
    s_ded_flag(FLAG_I) |=> status_register[FLAG_I] == $past(cmd_in.op[0])
      && status_register[6:0] == $past(status_register[6:0]))
    else $error("global interrupt flag op wrong");

  a_other_dedicated: assert property ( // [RULE8]
    (s_ded_flag(FLAG_S) or s_ded_flag(FLAG_V) or s_ded_flag(FLAG_T) or
      s_ded_flag(FLAG_H)) |=> status_register[$past(cmd_in.op[3:1])] == $past(cmd_in.op[0]))
    else $error("dedicated S/V/T/H op wrong");

  a_flag_effects: assert property ( // [RULE9]
    (s_exec_of(nibble_swap) or s_exec_of(transfer_flag_to_reg_bit)) |=>
      status_register == $past(status_register))
    else $error("swap or load altered flags");

  a_shift_keeps_flags: assert property ( // [RULE9]
    s_exec_of(arith_shift_right) |=>
      status_register[7:4] == $past(status_register[7:4])
      && status_register[FLAG_Z] == (result == 8'h00)
      && status_register[FLAG_V] == (status_register[FLAG_N] ^ status_register[FLAG_C]))
    else $error("shift flag update wrong");

  a_store_only_t: assert property ( // [RULE9]
    s_exec_of(reg_bit_to_transfer_flag) |=>
      status_register[5:0] == $past(status_register[5:0])
      && status_register[FLAG_I] == $past(status_register[FLAG_I]))
    else $error("bit store altered other flags");

  // ****************************************************************
  // Bus, refusal and hold assertions
  // ****************************************************************
  // Reads are checked one edge after the request, when dat_o stands
  sequence s_read_of(logic [3:0] a);
    cyc_i && stb_i && !we_i && !ack_o && adr_i == a;
  endsequence

  sequence s_ded_any;
    exec && cmd_in.op[4];
  endsequence

  sequence s_illegal_cmd;
    exec && !cmd_in.op[4] && cmd_in.op[3:0] > 4'h5;
  endsequence

  a_ack_follows_req: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged after one cycle");

  a_ack_needs_req: assert property (
    ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("ack given without a request");

  a_read_operand: assert property (
    s_read_of(ADR_OPERAND) |=> dat_o == {24'h00_0000, $past(operand)})
    else $error("operand read data wrong");

  a_read_result: assert property (
    s_read_of(ADR_RESULT) |=> dat_o[7:0] == $past(result)
      && dat_o[RES_ILLEGAL_BIT] == $past(illegal) && dat_o[31:9] == 23'h00_0000)
    else $error("result read data wrong");

  a_read_status: assert property (
    s_read_of(ADR_STATUS) |=> dat_o == {24'h00_0000, $past(status_register)})
    else $error("status read data wrong");

  // The command offset reads back as zero like any unmapped one
  a_read_unmapped: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && adr_i != ADR_OPERAND
      && adr_i != ADR_RESULT && adr_i != ADR_STATUS) |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_operand_write: assert property (
    wr && adr_i == ADR_OPERAND |=> operand == $past(dat_i[7:0]))
    else $error("operand write lost");

  // Ops only read the operand, so software can run several ops on one value
  a_operand_kept: assert property (
    !(wr && adr_i == ADR_OPERAND) |=> $stable(operand))
    else $error("operand changed without a write");

  a_status_quiet: assert property (
    !(exec || (wr && adr_i == ADR_STATUS)) |=> $stable(status_register))
    else $error("flags changed without a command or write");

  // Writes to the result offset and all flag-only ops leave it alone
  a_result_kept: assert property (
    !(exec && (cmd_in.op == arith_shift_right || cmd_in.op == nibble_swap
      || cmd_in.op == transfer_flag_to_reg_bit)) |=> $stable(result))
    else $error("result changed without a result-writing op");

  a_illegal_inert: assert property (
    s_illegal_cmd |=> illegal && $stable(status_register) && $stable(result))
    else $error("illegal command had an effect");

  a_legal_clears: assert property (
    exec && (cmd_in.op[4] || cmd_in.op[3:0] <= 4'h5) |=> !illegal)
    else $error("illegal flag not cleared by a legal command");

  a_ded_others_kept: assert property ( // [RULE6] [RULE8]
    s_ded_any |=> ((status_register ^ $past(status_register))
      & ~(8'h01 << $past(cmd_in.op[3:1]))) == 8'h00)
    else $error("dedicated op moved another flag");

  a_bit_op_others: assert property ( // [RULE4]
    (s_exec_of(status_bit_set) or s_exec_of(status_bit_clear)) |=>
      ((status_register ^ $past(status_register))
        & ~(8'h01 << $past(cmd_in.bitsel))) == 8'h00)
    else $error("status bit op moved another flag");

  a_load_others: assert property ( // [RULE5]
    s_exec_of(transfer_flag_to_reg_bit) |=>
      ((result ^ $past(operand)) & ~(8'h01 << $past(cmd_in.bitsel))) == 8'h00)
    else $error("bit load changed another result bit");

endmodule : bfo_unit

// ==== sim/bfo_core_model.sv ====
// Core-side model: the decoder and register file issuing register-bus cycles.
// Assumes the unit answers each classic Wishbone cycle; the bench bounds waits.
`timescale 1ns/10ps
module bfo_core_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // One single cycle; request held until ack is seen at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [3:0] s,
           input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released lines show junk so a stale value is never mistaken for data
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : bus
endmodule : bfo_core_model

// ==== sim/tb_bfo_unit.sv ====
// Self-checking bench for the bit and flag operations unit.
// Assumes the core model drives the register bus; 10 MHz clock.
`timescale 1ns/10ps
module tb_bfo_unit;
  import bfo_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] opnd;
    logic [7:0] pre;
    logic [7:0] res;
    logic [7:0] st;
  } bfo_row_t;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0] status, result, exp;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  bfo_row_t rows [10] = '{
    '{8'h00, 8'h81, 8'h00, 8'hc0, 8'h05}, '{8'h00, 8'h01, 8'hf0, 8'h00, 8'hfb},
    '{8'h00, 8'h40, 8'h0f, 8'h20, 8'h00}, '{8'h01, 8'h3c, 8'h5a, 8'hc3, 8'h5a},
    '{8'ha4, 8'h20, 8'h00, 8'hc3, 8'h40}, '{8'h04, 8'h20, 8'hff, 8'hc3, 8'hbf},
    '{8'h45, 8'h00, 8'h40, 8'h04, 8'h40}, '{8'he5, 8'hff, 8'hbf, 8'h7f, 8'hbf},
    '{8'he2, 8'h00, 8'h00, 8'h7f, 8'h80}, '{8'h03, 8'h00, 8'hff, 8'h7f, 8'hfe}};

  bfo_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .status_register_o(status), .result_o(result));
  bfo_core_model M (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // A full run costs far fewer than this many cycles; reaching the count means a hang
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [7:0] d);
    M.bus(1'b1, a, 4'h1, {24'h0, d}, q);
  endtask : wr

  task run(input logic [7:0] c, input logic [7:0] o, input logic [7:0] p);
    wr(ADR_OPERAND, o);
    wr(ADR_STATUS, p);
    wr(ADR_CMD, c);
    @(posedge clk_i);
    #1;
  endtask : run

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check(status, 8'h00);
    foreach (rows[i]) begin
      run(rows[i].cmd, rows[i].opnd, rows[i].pre);
      check(result, rows[i].res);
      check(status, rows[i].st);
    end
    $display("table rows done");
    for (int f = 0; f < 8; f++) begin
      for (int v = 0; v < 2; v++) begin
        exp = v[0] ? (8'h01 << f) : ~(8'h01 << f);
        run({4'b0001, f[2:0], v[0]}, 8'h00, v[0] ? 8'h00 : 8'hff);
        check(status, exp);
      end
    end
    $display("dedicated flag ops done");
    run(8'h06, 8'h55, 8'h33);
    check(status, 8'h33);
    M.bus(1'b0, ADR_RESULT, 4'h0, 32'h0, q);
    check(q, 32'h17f);
    run(8'h01, 8'h5a, 8'h33);
    check(result, 8'ha5);
    check(status, 8'h33);
    wr(ADR_RESULT, 8'haa);
    M.bus(1'b1, ADR_STATUS, 4'h0, 32'h77, q);
    M.bus(1'b0, ADR_RESULT, 4'h0, 32'h0, q);
    check(q, 32'h0a5);
    M.bus(1'b0, ADR_STATUS, 4'h0, 32'h0, q);
    check(q, 32'h033);
    M.bus(1'b0, 4'h2, 4'h0, 32'h0, q);
    check(q, 32'h0);
    M.bus(1'b0, ADR_OPERAND, 4'h0, 32'h0, q);
    check(q, 32'h05a);
    $display("refusals done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check(status, 8'h00);
    check(result, 8'h00);
    M.bus(1'b0, ADR_OPERAND, 4'h0, 32'h0, q);
    check(q, 32'h0);
    $display("mid-run reset done");
    tally_and_finish;
  end
endmodule : tb_bfo_unit
